/* File: inc/pd_ctrl_pkg.sv */
// types for the power-down controller
package pd_ctrl_pkg;
	typedef enum logic [2:0] {
		ST_WAIT_PG,
		ST_RUN,
		ST_PARK,
		ST_OFF,
		ST_LOCK,
		ST_UNGATE
	} pd_state_t;
	typedef enum logic [1:0] {
		LEG_LOW,
		LEG_HIGH,
		LEG_HIZ,
		LEG_CLOCK
	} leg_mode_t;
endpackage : pd_ctrl_pkg

/* File: inc/pd_ctrl_regs.svh */
// constants for the power-down controller
`ifndef PD_CTRL_REGS_SVH
`define PD_CTRL_REGS_SVH
// register offsets (byte addresses)
`define PD_REG_MODE 4'h0
`define PD_REG_STATUS 4'h4
// mode register fields
`define PD_MODE_CPU0 0
`define PD_MODE_CPU1 1
`define PD_MODE_CPU2 2
`define PD_MODE_SRC 3
`define PD_MODE_DOT 4
`define PD_MODE_RESET 5'h00
// status register fields
`define PD_STAT_ARMED 0
`define PD_STAT_DOWN 1
`define PD_STAT_LOCKED 2
`define PD_STAT_RUN 3
// timing
`define PD_CLK_MHZ 100
`define PD_UP_LATENCY_US 1800
`define PD_UP_CYCLES (`PD_UP_LATENCY_US * `PD_CLK_MHZ)
`define PD_HIGH_US 300
`define PD_HIGH_CYCLES (`PD_HIGH_US * `PD_CLK_MHZ)
`define PD_INIT_WIN_US 10
`define PD_INIT_WIN_CYCLES (`PD_INIT_WIN_US * `PD_CLK_MHZ)
`endif

/* File: test/pm_model.sv */
// power-management partner: shared pin and pll lock
`timescale 1ns/1ps
`default_nettype none
module pm_model (
	// clock, reset
	input wire logic core_clk,
	input wire logic rst,
	// bench commands
	input wire logic arm,
	input wire logic init_down,
	input wire logic want_down,
	input wire logic [7:0] lock_delay,
	// device side
	input wire logic vco_enable,
	output logic power_good_strobe_n,
	output logic pll_locked
);
	logic [1:0] win_q;
	logic [7:0] lock_q;
	// cycles since arming, saturating
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) win_q <= 2'h0;
		else if (arm && win_q != 2'h3) win_q <= win_q + 2'h1;
	end
	// initial request two cycles after arming, well inside the window
	// pin rests high on its pull-up until armed
	assign power_good_strobe_n = ~arm | want_down | (init_down & win_q[1]);
	// lock lags the vco by lock_delay cycles; lost at once when it stops
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) lock_q <= 8'h00;
		else if (!vco_enable) lock_q <= 8'h00;
		else if (lock_q != lock_delay) lock_q <= lock_q + 8'h01;
	end
	assign pll_locked = vco_enable & (lock_q == lock_delay);
endmodule : pm_model
`default_nettype wire

/* File: test/tb.sv */
// bench for the power-down controller
`timescale 1ns/1ps
`default_nettype none
module tb;
	import pd_ctrl_pkg::*;
	localparam int UP = 50;
	localparam int HI = 20;
	logic core_clk = 1'b0, rst = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0, pin_n, pll_locked, seen;
	logic clk_en = 1'b1;
	logic cpu_clock_complement = 1'b0, se_clock = 1'b0, arm = 1'b0, init_down = 1'b0, want_down = 1'b0;
	logic osc_enable, vco_enable, se_run, power_down_state;
	logic [3:0] reg_addr = 4'h0;
	logic [31:0] reg_wdata = 32'h0, reg_rdata, rd_q;
	logic [7:0] lock_delay = 8'h04;
	logic [2:0] half = 3'h3, cc_q = 3'h0;
	logic [4:0] diff_comp_oe, mode_m = 5'h00;
	leg_mode_t diff_true_mode [5];
	int n_mismatch = 0, cmp_count = 0;
	// core clock
	initial begin
		forever #5 core_clk = ~core_clk;
	end
	// cpu complement clock with a per-pass half period, so parking is seen at several rates
	always @(posedge core_clk) begin
		cc_q <= (cc_q >= half - 3'h1) ? 3'h0 : cc_q + 3'h1;
		if (cc_q >= half - 3'h1) cpu_clock_complement <= ~cpu_clock_complement;
		se_clock <= ~se_clock;
	end
	clock_gen_power_down_control #(.UP_CYCLES(UP), .HIGH_CYCLES(HI), .INIT_CYCLES(10), .N_DIFF(5)) dut_u (
		.core_clk(core_clk), .rst(rst), .clk_en(clk_en), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .power_good_strobe_n(pin_n),
		.cpu_clock_complement(cpu_clock_complement), .se_clock(se_clock), .pll_locked(pll_locked),
		.osc_enable(osc_enable), .vco_enable(vco_enable), .se_run(se_run), .diff_true_mode(diff_true_mode),
		.diff_comp_oe(diff_comp_oe), .power_down_state(power_down_state));
	pm_model pm_u (.core_clk(core_clk), .rst(rst), .arm(arm), .init_down(init_down), .want_down(want_down),
		.lock_delay(lock_delay), .vco_enable(vco_enable), .power_good_strobe_n(pin_n), .pll_locked(pll_locked));
	task automatic chk(input logic [63:0] s, input logic [63:0] e, input string what);
		cmp_count++;
		if (s !== e) begin
			n_mismatch++;
			$display("unexpected %s expected %h seen %h", what, e, s);
		end
	endtask : chk
	task automatic end_of_test();
		if (n_mismatch == 0 && cmp_count > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask : end_of_test
	// bounded wait: sel 0 state, 1 se_run, 2 oscillator
	task automatic wait_for(input int sel, input logic v, input int bound);
		logic [2:0] st;
		for (int i = 0; i < bound; i++) begin
			@(posedge core_clk);
			#1;
			st = {osc_enable, se_run, power_down_state};
			if (st[sel] === v) return;
		end
		n_mismatch++;
		$display("unexpected wait %0d expected %b seen timeout", sel, v);
		end_of_test();
	endtask : wait_for
	task automatic wr(input logic [3:0] a, input logic [31:0] d);
		@(posedge core_clk);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge core_clk);
		reg_wr <= 1'b0;
	endtask : wr
	// read data lands the cycle after the strobe
	task automatic rd(input logic [3:0] a);
		@(posedge core_clk);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge core_clk);
		reg_rd <= 1'b0;
		#1 rd_q = reg_rdata;
	endtask : rd
	// one entry and exit; expectations come from the mode model
	task automatic pd_cycle();
		@(posedge core_clk);
		want_down <= 1'b1;
		wait_for(0, 1'b1, 40);
		wait_for(2, 1'b0, 200);
		chk({power_down_state, se_run, vco_enable, diff_comp_oe}, 8'h80, "parked");
		for (int i = 0; i < 5; i++)
			chk(diff_true_mode[i], mode_m[i] ? LEG_HIZ : LEG_HIGH, "leg");
		rd(4'h4);
		chk(rd_q & 32'hb, 32'h3, "status down");
		@(posedge core_clk);
		want_down <= 1'b0;
		repeat (HI) @(posedge core_clk);
		#1;
		for (int i = 0; i < 5; i++)
			chk(diff_true_mode[i] == LEG_HIZ, 1'b0, "floating");
		wait_for(1, 1'b1, UP + 20);
		chk({pll_locked, osc_enable, diff_comp_oe}, 7'h7f, "release");
		for (int i = 0; i < 5; i++)
			chk(diff_true_mode[i], LEG_CLOCK, "run leg");
	endtask : pd_cycle
	initial begin
		void'($urandom(32'hbe3c62a4));
		@(posedge core_clk);
		#1;
		chk({osc_enable, vco_enable, se_run, power_down_state, diff_comp_oe, reg_rdata}, 41'h18000000000, "reset");
		@(posedge core_clk);
		rst <= 1'b0;
		rd(4'h0);
		chk(rd_q, 32'h0, "mode reset");
		// power-down wanted from power-on
		@(posedge core_clk);
		arm <= 1'b1;
		init_down <= 1'b1;
		wait_for(0, 1'b1, 40);
		chk(se_run, 1'b0, "init down");
		@(posedge core_clk);
		init_down <= 1'b0;
		wait_for(1, 1'b1, UP + 20);
		rd(4'h4);
		chk(rd_q & 32'hb, 32'h9, "status run");
		for (int k = 0; k < 6; k++) begin
			@(posedge core_clk);
			// blocking: the write just below must carry this pass's value
			mode_m = (k == 0) ? 5'h00 : (k == 1) ? 5'h1f : 5'($urandom);
			half <= 3'(2 + $urandom % 3);
			lock_delay <= k[0] ? 8'h1e : 8'(2 + $urandom % 4);
			wr(4'h0, {27'h0, mode_m});
			rd(4'h0);
			chk(rd_q, {27'h0, mode_m}, "mode rw");
			pd_cycle();
		end
		// a write while the clock enable is low must not land
		@(posedge core_clk);
		clk_en <= 1'b0;
		wr(4'h0, {27'h0, ~mode_m});
		@(posedge core_clk);
		clk_en <= 1'b1;
		rd(4'h0);
		chk(rd_q, {27'h0, mode_m}, "frozen write");
		// unmapped place and read-only status
		wr(4'h8, 32'hffffffff);
		wr(4'h4, 32'h0);
		rd(4'h8);
		chk(rd_q, 32'h0, "unmapped");
		rd(4'h4);
		chk(rd_q & 32'hb, 32'h9, "status ro");
		rd(4'h0);
		chk(rd_q, {27'h0, mode_m}, "mode kept");
		// a one-cycle request cannot be seen on two complement edges
		@(posedge core_clk);
		want_down <= 1'b1;
		seen = 1'b0;
		@(posedge core_clk);
		want_down <= 1'b0;
		repeat (30) begin
			@(posedge core_clk);
			#1 seen = seen | power_down_state;
		end
		chk(seen, 1'b0, "short request");
		end_of_test();
	end
endmodule : tb
`default_nettype wire

/* File: verilog/clock_gen_power_down_control.sv */
// power-down entry and exit control for a clock generator
`timescale 1ns/1ps
`default_nettype none
`include "pd_ctrl_regs.svh"
module clock_gen_power_down_control #(
	parameter int UP_CYCLES = `PD_UP_CYCLES,
	parameter int HIGH_CYCLES = `PD_HIGH_CYCLES,
	parameter int INIT_CYCLES = `PD_INIT_WIN_CYCLES,
	parameter int N_DIFF = 5
) (
	// clock, reset, enable
	input wire logic core_clk,
	input wire logic rst,
	input wire logic clk_en,
	// register port
	input wire logic [3:0] reg_addr,
	input wire logic [31:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [31:0] reg_rdata,
	// shared pin, sampled synchronously
	input wire logic power_good_strobe_n,
	// internal clocks and analog status
	input wire logic cpu_clock_complement,
	input wire logic se_clock,
	input wire logic pll_locked,
	// analog controls
	output logic osc_enable,
	output logic vco_enable,
	// single-ended output gate (1 = running)
	output logic se_run,
	// per differential output, index per mode bit layout
	output pd_ctrl_pkg::leg_mode_t diff_true_mode [N_DIFF],
	output logic [N_DIFF-1:0] diff_comp_oe,
	output logic power_down_state
);
	import pd_ctrl_pkg::*;

	pd_state_t state_q;
	logic [N_DIFF-1:0] mode_q;
	logic armed_q;
	logic req_s1_q, req_s2_q;
	logic cc_q, se_q;
	logic det_q;
	logic [31:0] cnt_q;
	logic [31:0] hi_cnt_q;
	logic [N_DIFF-1:0] parked_q;
	logic [N_DIFF-1:0] hiz_hold_q;
	logic lock_s1_q, lock_s2_q;
	wire cc_fall = cc_q & ~cpu_clock_complement;
	wire cc_rise = ~cc_q & cpu_clock_complement;
	wire se_fall = se_q & ~se_clock;

	// pin role, armed once strobe seen low
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			armed_q <= 1'b0;
		end else if (clk_en && !power_good_strobe_n) begin
			armed_q <= 1'b1;
		end
	end

	// request synchroniser, two stages on core clock
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			req_s1_q <= 1'b0;
			req_s2_q <= 1'b0;
			lock_s1_q <= 1'b0;
			lock_s2_q <= 1'b0;
		end else if (clk_en) begin
			req_s1_q <= power_good_strobe_n & armed_q;
			req_s2_q <= req_s1_q;
			lock_s1_q <= pll_locked;
			lock_s2_q <= lock_s1_q;
		end
	end

	// edge history of the monitored clocks
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			cc_q <= 1'b0;
			se_q <= 1'b0;
		end else if (clk_en) begin
			cc_q <= cpu_clock_complement;
			se_q <= se_clock;
		end
	end

	// detection: high at two consecutive complement rises
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			det_q <= 1'b0;
		end else if (clk_en) begin
			if (!req_s2_q) begin
				det_q <= 1'b0;
			end else if (cc_rise) begin
				det_q <= 1'b1;
			end
		end
	end
	// a second high rise while det_q stands completes detection
	wire detected = det_q & req_s2_q & cc_rise;

	// mode register, one bit per differential group
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			mode_q <= N_DIFF'(`PD_MODE_RESET);
		end else if (clk_en && reg_wr && reg_addr == `PD_REG_MODE) begin
			mode_q <= reg_wdata[N_DIFF-1:0];
		end
	end

	// read data one cycle after the strobe; unmapped reads zero
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			reg_rdata <= 32'h0;
		end else if (clk_en) begin
			reg_rdata <= 32'h0;
			if (reg_rd && reg_addr == `PD_REG_MODE) begin
				reg_rdata[N_DIFF-1:0] <= mode_q;
			end else if (reg_rd && reg_addr == `PD_REG_STATUS) begin
				reg_rdata[`PD_STAT_ARMED] <= armed_q;
				reg_rdata[`PD_STAT_DOWN] <= power_down_state;
				reg_rdata[`PD_STAT_LOCKED] <= lock_s2_q;
				reg_rdata[`PD_STAT_RUN] <= (state_q == ST_RUN);
			end
		end
	end

	// main sequence; park before oscillator off
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			state_q <= ST_WAIT_PG;
			cnt_q <= 32'h0;
		end else if (clk_en) begin
			unique case (state_q)
				ST_WAIT_PG: begin
					// initial power-down honoured inside the start-up window
					cnt_q <= 32'h0;
					if (armed_q) begin
						state_q <= ST_LOCK;
					end
				end
				ST_RUN: begin
					if (detected) begin
						state_q <= ST_PARK;
					end
				end
				ST_PARK: begin
					// waits on the clock edges alone, frequency-agnostic
					if (&parked_q && !se_run) begin
						state_q <= ST_OFF;
					end
				end
				ST_OFF: begin
					cnt_q <= 32'h0;
					if (!req_s2_q) begin
						state_q <= ST_LOCK;
					end
				end
				ST_LOCK: begin
					// waits lock, bounded by the latency budget
					// lock alone never closes the window in which an initial request still parks
					cnt_q <= cnt_q + 32'h1;
					if (req_s2_q && cnt_q < 32'(INIT_CYCLES)) begin
						state_q <= ST_PARK;
					end else if ((lock_s2_q && cnt_q >= 32'(INIT_CYCLES)) || cnt_q >= 32'(UP_CYCLES - 1)) begin
						state_q <= ST_UNGATE;
					end
				end
				ST_UNGATE: begin
					// release on a complement falling edge
					if (cc_fall) begin
						state_q <= ST_RUN;
					end
				end
				default: state_q <= ST_WAIT_PG;
			endcase
		end
	end

	// oscillator and vco stay on until every output is parked
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			osc_enable <= 1'b1;
			vco_enable <= 1'b1;
			power_down_state <= 1'b0;
		end else if (clk_en) begin
			osc_enable <= (state_q != ST_OFF);
			vco_enable <= (state_q != ST_OFF);
			power_down_state <= (state_q == ST_PARK) || (state_q == ST_OFF);
		end
	end

	// single-ended outputs stop low on their falling edge
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			se_run <= 1'b0;
		end else if (clk_en) begin
			if (state_q == ST_PARK && se_fall) begin
				se_run <= 1'b0;
			end else if (state_q == ST_UNGATE && cc_fall) begin
				se_run <= 1'b1;
			end
		end
	end

	// each differential output parks on a complement fall
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			parked_q <= '1;
		end else if (clk_en) begin
			if (state_q == ST_PARK && cc_fall) begin
				parked_q <= '1;
			end else if (state_q == ST_UNGATE && cc_fall) begin
				parked_q <= '0;
			end
		end
	end

	// floated outputs pulled high within the budget after exit
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			hi_cnt_q <= 32'h0;
			hiz_hold_q <= '0;
		end else if (clk_en) begin
			if (state_q == ST_PARK || state_q == ST_OFF) begin
				hi_cnt_q <= 32'h0;
				hiz_hold_q <= mode_q;
			end else if (hiz_hold_q != '0) begin
				hi_cnt_q <= hi_cnt_q + 32'h1;
				// half the budget leaves margin for the analog rise
				if (hi_cnt_q >= 32'(HIGH_CYCLES / 2)) begin
					hiz_hold_q <= '0;
				end
			end
		end
	end

	// leg drive per output from its mode bit
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			for (int i = 0; i < N_DIFF; i++) begin
				diff_true_mode[i] <= LEG_HIGH;
			end
			diff_comp_oe <= '0;
		end else if (clk_en) begin
			for (int i = 0; i < N_DIFF; i++) begin
				// released on the same edge as the single-ended gate
				if (!parked_q[i] || (state_q == ST_UNGATE && cc_fall)) begin
					diff_true_mode[i] <= LEG_CLOCK;
					diff_comp_oe[i] <= 1'b1;
				end else if (hiz_hold_q[i] && state_q != ST_PARK && state_q != ST_OFF) begin
					diff_true_mode[i] <= LEG_HIZ;
					diff_comp_oe[i] <= 1'b0;
				end else begin
					diff_true_mode[i] <= (mode_q[i] && state_q != ST_WAIT_PG && state_q != ST_LOCK
						&& state_q != ST_UNGATE) ? LEG_HIZ : LEG_HIGH;
					diff_comp_oe[i] <= 1'b0;
				end
			end
		end
	end

	// checks
	chk_detect_parks: assert property (@(posedge core_clk) disable iff (rst)
		(clk_en && state_q == ST_RUN && detected) |=> state_q == ST_PARK)
		else $error("detection did not enter park");
	chk_osc_after_park: assert property (@(posedge core_clk) disable iff (rst)
		!osc_enable |-> &parked_q && !se_run)
		else $error("oscillator stopped before outputs parked");
	chk_armed_first: assert property (@(posedge core_clk) disable iff (rst)
		!armed_q |-> state_q == ST_WAIT_PG)
		else $error("sequence left wait before power-good");
	chk_sync_stage: assert property (@(posedge core_clk) disable iff (rst)
		(clk_en && $rose(req_s2_q)) |-> $past(req_s1_q))
		else $error("request bypassed synchroniser");
	chk_mode_hiz: assert property (@(posedge core_clk) disable iff (rst)
		(clk_en && state_q == ST_OFF && mode_q[0] && parked_q[0]) |=> diff_true_mode[0] == LEG_HIZ)
		else $error("mode one did not float true leg");
	chk_mode_drive: assert property (@(posedge core_clk) disable iff (rst)
		(clk_en && state_q == ST_OFF && !mode_q[0]) |=> diff_true_mode[0] == LEG_HIGH && !diff_comp_oe[0])
		else $error("mode zero did not drive true high");
	chk_ungate_edge: assert property (@(posedge core_clk) disable iff (rst)
		(state_q == ST_UNGATE && $past(state_q) != ST_UNGATE) |-> !se_run)
		else $error("output ungated before lock");
	chk_together: assert property (@(posedge core_clk) disable iff (rst)
		$rose(se_run) |-> $fell(parked_q[0]))
		else $error("outputs not enabled together");
	cov_power_down: cover property (@(posedge core_clk) disable iff (rst) state_q == ST_OFF);
	cov_exit: cover property (@(posedge core_clk) disable iff (rst) $rose(se_run));
	cov_initial_pd: cover property (@(posedge core_clk) disable iff (rst)
		state_q == ST_LOCK ##1 state_q == ST_PARK);
endmodule : clock_gen_power_down_control
`default_nettype wire
